// ==== verif/cxwake_ctrl_model.sv ====
// bus controller model: drives the transmit input
// assumes same clock as the design, go pulsed by the bench
`timescale 1ns/1ps
`default_nettype none
module cxwake_ctrl_model
(
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] len,
  output logic tx_in
);
  initial tx_in = 1'b1;
  always @(posedge clk)
  begin
    if (go)
    begin
      tx_in <= 1'b0;
      repeat (len) @(posedge clk);
      tx_in <= 1'b1;
    end
  end
endmodule // cxwake_ctrl_model
`default_nettype wire

// ==== verif/cxwake_top_bench.sv ====
// bench for the transceiver fault and wake logic
// assumes a 10 MHz clock and the controller model beside it
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module cxwake_top_bench;
  logic clk = 0, sys_rst = 1, bus_rx = 1, bus_monitor = 1, overheat_in = 0, overcur_in = 0, go = 0, tx_in;
  logic [15:0] len = 16'h0000;
  cxwake_pkg::cxwake_req_t req = '0;
  logic [7:0] rdata;
  logic irq, rx_out, drive_dominant, cell_enable;
  logic [1:0] slew_sel;
  int mismatches = 0, n_checks = 0, v;
  int v_bad [2] = '{5, 5000};
  cxwake_top dut_u (.clk(clk), .sys_rst(sys_rst), .req(req), .rdata(rdata), .irq(irq), .tx_in(tx_in),
    .rx_out(rx_out), .bus_rx(bus_rx), .bus_monitor(bus_monitor), .overheat_in(overheat_in),
    .overcur_in(overcur_in), .drive_dominant(drive_dominant), .slew_sel(slew_sel), .cell_enable(cell_enable));
  cxwake_ctrl_model ctl_u (.clk(clk), .go(go), .len(len), .tx_in(tx_in));
  initial forever #50 clk = ~clk;
  // ==================================================================
  // helpers
  function automatic logic [7:0] wake_exp(input int n);
    return (n >= 3) ? 8'h08 : 8'h00;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req.rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  task automatic pl(input int w);
    @(posedge clk) bus_monitor <= 1'b0;
    repeat (w) @(posedge clk);
    bus_monitor <= 1'b1;
    repeat (30) @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #5_000_000 mismatches++;
    give_verdict();
  end
  // ==================================================================
  // scenarios
  initial
  begin
    v = $urandom(70786);
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd(4'h0, 8'h02);
    rd(4'hF, 8'h00);
    wr(4'hF, 8'hFF);
    rd(4'h2, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      v = (i < 4) ? i : $urandom % 4;
      wr(4'h0, 8'(v << 2) | 8'h02);
      repeat (2) @(posedge clk);
      `CHK(slew_sel, 2'(v))
    end
    bus_rx <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK(rx_out, 1'b0)
    bus_rx <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK(rx_out, 1'b1)
    len <= 16'd3600;
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK(drive_dominant, 1'b1)
    repeat (3550) @(posedge clk);
    `CHK(drive_dominant, 1'b0)
    rd(4'h1, 8'h04);
    repeat (60) @(posedge clk);
    len <= 16'd20;
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(drive_dominant, 1'b1)
    wr(4'h1, 8'h04);
    rd(4'h1, 8'h00);
    wr(4'h2, 8'h01);
    overheat_in <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(irq, 1'b1)
    overheat_in <= 1'b0;
    repeat (4) @(posedge clk);
    rd(4'h1, 8'h01);
    wr(4'h1, 8'h01);
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    overcur_in <= 1'b1;
    repeat (6) @(posedge clk);
    overcur_in <= 1'b0;
    `CHK(irq, 1'b0)
    rd(4'h1, 8'h02);
    wr(4'h1, 8'h02);
    wr(4'h0, 8'h03);
    bus_rx <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK(rx_out, 1'b1)
    `CHK(cell_enable, 1'b0)
    bus_rx <= 1'b1;
    pl(6);
    pl(4999);
    rd(4'h1, wake_exp(2));
    pl(6 + $urandom % 300);
    repeat (4) @(posedge clk);
    rd(4'h1, wake_exp(3));
    wr(4'h0, 8'h03);
    rd(4'h1, 8'h08);
    wr(4'h0, 8'h02);
    rd(4'h1, 8'h00);
    wr(4'h0, 8'h03);
    foreach (v_bad[k])
    begin
      pl(20);
      pl(20);
      pl(v_bad[k]);
      pl(20);
      pl(20);
      rd(4'h1, 8'h00);
      wr(4'h0, 8'h02);
      wr(4'h0, 8'h03);
    end
    pl(20);
    repeat (5100) @(posedge clk);
    pl(20);
    rd(4'h1, 8'h00);
    pl(20);
    pl(20);
    repeat (4) @(posedge clk);
    rd(4'h1, 8'h08);
    wr(4'h0, 8'h02);
    wr(4'h0, 8'h01);
    for (int i = 0; i < 3; i++)
      pl(20);
    rd(4'h1, 8'h00);
    give_verdict();
  end
endmodule // cxwake_top_bench
`default_nettype wire

// ==== verilog/cxwake_pkg.sv ====
// cxwake_pkg: constants, register map and types for the bus transceiver fault and wake logic
// assumes a single 10 MHz clock and a plain register port
// ==================================================================
package cxwake_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned DOM_TIMEOUT_US = 350;
  localparam int unsigned DOM_TIMEOUT_CYC = DOM_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WAKE_MIN_NS = 500;
  localparam int unsigned WAKE_MIN_CYC = (WAKE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned WAKE_MAX_US = 500;
  localparam int unsigned WAKE_MAX_CYC = WAKE_MAX_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WAKE_PULSES = 3;
  localparam int unsigned CNT_W = 13;
  // register offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MASK = 4'h2;
  // control field positions
  localparam int unsigned CTRL_SLEEP = 0;
  localparam int unsigned CTRL_WAKE_EN = 1;
  localparam int unsigned CTRL_SLEW_LO = 2;
  localparam logic [3:0] CTRL_RESET = 4'h2;
  // status field positions
  localparam int unsigned ST_OVERHEAT = 0;
  localparam int unsigned ST_OVERCUR = 1;
  localparam int unsigned ST_DOMTO = 2;
  localparam int unsigned ST_WAKE = 3;
  localparam logic [3:0] MASK_RESET = 4'h0;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cxwake_req_t;
  typedef enum logic [1:0] {
    CXWAKE_IDLE = 2'b01,
    CXWAKE_HIGH = 2'b10
  } cxwake_pulse_t;
endpackage

// ==== verilog/cxwake_top.sv ====
// cxwake_top: transmit timeout, fault flags, sleep, bus wake detector, register port
// assumes asynchronous analog flags and bus monitor, controller on the same clock
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module cxwake_top
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire cxwake_pkg::cxwake_req_t req,
  output logic [7:0] rdata,
  output logic irq,
  input wire logic tx_in,
  output logic rx_out,
  input wire logic bus_rx,
  input wire logic bus_monitor,
  input wire logic overheat_in,
  input wire logic overcur_in,
  output logic drive_dominant,
  output logic [1:0] slew_sel,
  output logic cell_enable
);
  // ==================================================================
  // input synchronisers
  logic [1:0] rx_s1, rx_s2;
  logic rx_q, mon_q, oh_q, oc_q;
  always_ff @(posedge clk)
  begin
    rx_s1 <= {bus_monitor, bus_rx};
    rx_s2 <= rx_s1;
  end
  logic [1:0] fl_s1, fl_s2;
  always_ff @(posedge clk)
  begin
    fl_s1 <= {overcur_in, overheat_in};
    fl_s2 <= fl_s1;
  end
  assign rx_q = rx_s2[0];
  assign mon_q = rx_s2[1];
  assign oh_q = fl_s2[0];
  assign oc_q = fl_s2[1];

  // ==================================================================
  // control register
  logic [3:0] ctrl;
  logic [3:0] status;
  logic [3:0] mask;
  logic sleep_mode, wake_en;
  logic wr_ctrl, wr_status, wr_mask;
  assign wr_ctrl = req.wr && (req.addr == cxwake_pkg::ADDR_CTRL);
  assign wr_status = req.wr && (req.addr == cxwake_pkg::ADDR_STATUS);
  assign wr_mask = req.wr && (req.addr == cxwake_pkg::ADDR_MASK);
  assign sleep_mode = ctrl[cxwake_pkg::CTRL_SLEEP];
  assign wake_en = ctrl[cxwake_pkg::CTRL_WAKE_EN];
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ctrl <= cxwake_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= req.wdata[3:0];
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mask <= cxwake_pkg::MASK_RESET;
    else if (wr_mask)
      mask <= req.wdata[3:0];
  end
  // normal mode entry: sleep bit written from one to zero
  logic enter_normal;
  assign enter_normal = wr_ctrl && sleep_mode && !req.wdata[cxwake_pkg::CTRL_SLEEP];

  // ==================================================================
  // dominant timeout
  logic [cxwake_pkg::CNT_W-1:0] dom_cnt;
  logic dom_fault;
  logic dom_expire;
  assign dom_expire = (dom_cnt == cxwake_pkg::CNT_W'(cxwake_pkg::DOM_TIMEOUT_CYC - 1)) && !tx_in;
  always_ff @(posedge clk)
  begin
    if (sys_rst || tx_in || sleep_mode)
      dom_cnt <= '0;
    else if (!dom_expire)
      dom_cnt <= dom_cnt + 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      dom_fault <= 1'b0;
    else if (tx_in)
      dom_fault <= 1'b0;
    else if (dom_expire)
      dom_fault <= 1'b1;
  end

  // ==================================================================
  // transmit and receive paths
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      drive_dominant <= 1'b0;
      rx_out <= 1'b1;
      cell_enable <= 1'b0;
      slew_sel <= 2'd0;
    end
    else
    begin
      drive_dominant <= !tx_in && !dom_fault && !dom_expire && !sleep_mode;
      rx_out <= sleep_mode ? 1'b1 : rx_q;
      cell_enable <= !sleep_mode;
      slew_sel <= ctrl[cxwake_pkg::CTRL_SLEW_LO +: 2];
    end
  end

  // ==================================================================
  // wake detector
  cxwake_pkg::cxwake_pulse_t pstate;
  logic [cxwake_pkg::CNT_W-1:0] width_cnt;
  logic [cxwake_pkg::CNT_W-1:0] gap_cnt;
  logic [1:0] pulse_cnt;
  logic wake_active;
  logic pulse_end, pulse_ok, pulse_bad, gap_out;
  assign wake_active = sleep_mode && wake_en;
  assign pulse_end = (pstate == cxwake_pkg::CXWAKE_HIGH) && mon_q;
  assign pulse_ok = pulse_end && (width_cnt > cxwake_pkg::CNT_W'(cxwake_pkg::WAKE_MIN_CYC))
                    && (width_cnt < cxwake_pkg::CNT_W'(cxwake_pkg::WAKE_MAX_CYC));
  assign pulse_bad = pulse_end && !pulse_ok;
  assign gap_out = (pulse_cnt != 2'd0) && (pstate == cxwake_pkg::CXWAKE_IDLE)
                   && (gap_cnt >= cxwake_pkg::CNT_W'(cxwake_pkg::WAKE_MAX_CYC));
  always_ff @(posedge clk)
  begin
    if (sys_rst || !wake_active)
      pstate <= cxwake_pkg::CXWAKE_IDLE;
    else
      case (pstate)
        cxwake_pkg::CXWAKE_IDLE: if (!mon_q) pstate <= cxwake_pkg::CXWAKE_HIGH;
        cxwake_pkg::CXWAKE_HIGH: if (mon_q) pstate <= cxwake_pkg::CXWAKE_IDLE;
        default: pstate <= cxwake_pkg::CXWAKE_IDLE;
      endcase
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst || pstate != cxwake_pkg::CXWAKE_HIGH)
      width_cnt <= cxwake_pkg::CNT_W'(1);
    else if (width_cnt != '1)
      width_cnt <= width_cnt + 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst || pstate != cxwake_pkg::CXWAKE_IDLE || pulse_cnt == 2'd0)
      gap_cnt <= '0;
    else if (gap_cnt != '1)
      gap_cnt <= gap_cnt + 1'b1;
  end
  logic wake_evt;
  assign wake_evt = pulse_ok && (pulse_cnt == 2'(cxwake_pkg::WAKE_PULSES - 1));
  always_ff @(posedge clk)
  begin
    if (sys_rst || !wake_active)
      pulse_cnt <= 2'd0;
    else if (pulse_bad || gap_out || wake_evt)
      pulse_cnt <= 2'd0;
    else if (pulse_ok)
      pulse_cnt <= pulse_cnt + 2'd1;
  end

  // ==================================================================
  // status, sticky with write one to clear (wake bit cleared on normal mode entry instead), set wins
  logic [3:0] ev;
  assign ev[cxwake_pkg::ST_OVERHEAT] = oh_q;
  assign ev[cxwake_pkg::ST_OVERCUR] = oc_q;
  assign ev[cxwake_pkg::ST_DOMTO] = dom_expire;
  assign ev[cxwake_pkg::ST_WAKE] = wake_evt;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_st
      always_ff @(posedge clk)
      begin
        if (sys_rst)
          status[gi] <= 1'b0;
        else if (ev[gi])
          status[gi] <= 1'b1;
        else if (gi == cxwake_pkg::ST_WAKE)
        begin
          if (enter_normal)
            status[gi] <= 1'b0;
        end
        else if (wr_status && req.wdata[gi])
          status[gi] <= 1'b0;
      end
    end
  endgenerate
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(status & mask);
  end
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rdata <= 8'h00;
    else if (req.rd)
      case (req.addr)
        cxwake_pkg::ADDR_CTRL: rdata <= {4'h0, ctrl};
        cxwake_pkg::ADDR_STATUS: rdata <= {4'h0, status};
        cxwake_pkg::ADDR_MASK: rdata <= {4'h0, mask};
        default: rdata <= 8'h00;
      endcase
    else
      rdata <= 8'h00;
  end

  // ==================================================================
  // checks
  property p_dom_release;
    @(posedge clk) disable iff (sys_rst) dom_expire |=> !drive_dominant;
  endproperty
  a_dom_release: assert property (p_dom_release) else $error("driver not released");
  property p_stay_off;
    @(posedge clk) disable iff (sys_rst) dom_fault && !tx_in |=> !drive_dominant;
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("driver on in fault");
  property p_domto_flag;
    @(posedge clk) disable iff (sys_rst) dom_expire |=> status[cxwake_pkg::ST_DOMTO];
  endproperty
  a_domto_flag: assert property (p_domto_flag) else $error("timeout flag missing");
  property p_wake_flag;
    @(posedge clk) disable iff (sys_rst) wake_evt |=> status[cxwake_pkg::ST_WAKE];
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("wake flag missing");
  property p_sleep_off;
    @(posedge clk) disable iff (sys_rst) sleep_mode |=> !drive_dominant && rx_out;
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("cell active in sleep");
  property p_bad_clear;
    @(posedge clk) disable iff (sys_rst) pulse_bad |=> pulse_cnt == 2'd0;
  endproperty
  a_bad_clear: assert property (p_bad_clear) else $error("counter kept on bad pulse");
  property p_gap_clear;
    @(posedge clk) disable iff (sys_rst) gap_out && !status[cxwake_pkg::ST_WAKE] |=> pulse_cnt == 2'd0 && !status[cxwake_pkg::ST_WAKE];
  endproperty
  a_gap_clear: assert property (p_gap_clear) else $error("gap did not clear");
  property p_wake_hold;
    @(posedge clk) disable iff (sys_rst) status[cxwake_pkg::ST_WAKE] && !enter_normal |=> status[cxwake_pkg::ST_WAKE];
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake flag dropped");
  property p_wake_dis;
    @(posedge clk) disable iff (sys_rst) !wake_en |=> !wake_evt;
  endproperty
  a_wake_dis: assert property (p_wake_dis) else $error("wake while disabled");
  // ==================================================================
  // path and register checks
  property p_rx_follow;
    @(posedge clk) disable iff (sys_rst) !sleep_mode |=> rx_out == $past(rx_q);
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("receive path wrong");
  property p_tx_follow;
    @(posedge clk) disable iff (sys_rst) !sleep_mode && !dom_fault && !dom_expire |=> drive_dominant == !$past(tx_in);
  endproperty
  a_tx_follow: assert property (p_tx_follow) else $error("transmit path wrong");
  property p_cell_off;
    @(posedge clk) disable iff (sys_rst) sleep_mode |=> !cell_enable;
  endproperty
  a_cell_off: assert property (p_cell_off) else $error("cell on in sleep");
  property p_cell_on;
    @(posedge clk) disable iff (sys_rst) !sleep_mode |=> cell_enable;
  endproperty
  a_cell_on: assert property (p_cell_on) else $error("cell off in normal");
  property p_slew;
    @(posedge clk) disable iff (sys_rst) 1'b1 |=> slew_sel == $past(ctrl[cxwake_pkg::CTRL_SLEW_LO +: 2]);
  endproperty
  a_slew: assert property (p_slew) else $error("slew setting wrong");
  property p_fault_set;
    @(posedge clk) disable iff (sys_rst) dom_expire |=> dom_fault;
  endproperty
  a_fault_set: assert property (p_fault_set) else $error("fault not latched");
  property p_fault_clear;
    @(posedge clk) disable iff (sys_rst) dom_fault && tx_in |=> !dom_fault;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault kept on recessive");
  property p_dom_bound;
    @(posedge clk) disable iff (sys_rst) 1'b1 |-> dom_cnt <= cxwake_pkg::CNT_W'(cxwake_pkg::DOM_TIMEOUT_CYC - 1);
  endproperty
  a_dom_bound: assert property (p_dom_bound) else $error("timeout counter overrun");
  property p_oh_flag;
    @(posedge clk) disable iff (sys_rst) oh_q |=> status[cxwake_pkg::ST_OVERHEAT];
  endproperty
  a_oh_flag: assert property (p_oh_flag) else $error("overheat flag missing");
  property p_oc_flag;
    @(posedge clk) disable iff (sys_rst) oc_q |=> status[cxwake_pkg::ST_OVERCUR];
  endproperty
  a_oc_flag: assert property (p_oc_flag) else $error("overcurrent flag missing");
  property p_pulse_inc;
    @(posedge clk) disable iff (sys_rst) wake_active && pulse_ok && pulse_cnt != 2'd2 |=> pulse_cnt == $past(pulse_cnt) + 2'd1;
  endproperty
  a_pulse_inc: assert property (p_pulse_inc) else $error("pulse not counted");
  sequence s_third_pulse;
    pulse_ok && pulse_cnt == 2'd2;
  endsequence
  sequence s_wake_set;
    status[cxwake_pkg::ST_WAKE] && pulse_cnt == 2'd0;
  endsequence
  property p_wake_third;
    @(posedge clk) disable iff (sys_rst) s_third_pulse |=> s_wake_set;
  endproperty
  a_wake_third: assert property (p_wake_third) else $error("third pulse gave no wake");
  property p_wake_only_evt;
    @(posedge clk) disable iff (sys_rst) !status[cxwake_pkg::ST_WAKE] && !wake_evt |=> !status[cxwake_pkg::ST_WAKE];
  endproperty
  a_wake_only_evt: assert property (p_wake_only_evt) else $error("wake flag without event");
  property p_width_min;
    @(posedge clk) disable iff (sys_rst) pulse_end && width_cnt <= cxwake_pkg::CNT_W'(cxwake_pkg::WAKE_MIN_CYC) |-> !pulse_ok;
  endproperty
  a_width_min: assert property (p_width_min) else $error("short pulse accepted");
  property p_width_max;
    @(posedge clk) disable iff (sys_rst) pulse_end && width_cnt >= cxwake_pkg::CNT_W'(cxwake_pkg::WAKE_MAX_CYC) |-> !pulse_ok;
  endproperty
  a_width_max: assert property (p_width_max) else $error("long pulse accepted");
  property p_wake_clear;
    @(posedge clk) disable iff (sys_rst) enter_normal && !wake_evt |=> !status[cxwake_pkg::ST_WAKE];
  endproperty
  a_wake_clear: assert property (p_wake_clear) else $error("wake flag kept in normal");
  property p_irq;
    @(posedge clk) disable iff (sys_rst) 1'b1 |=> irq == |$past(status & mask);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");
  property p_rd_idle;
    @(posedge clk) disable iff (sys_rst) !req.rd |=> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_rd_status;
    @(posedge clk) disable iff (sys_rst) req.rd && req.addr == cxwake_pkg::ADDR_STATUS |=> rdata == {4'h0, $past(status)};
  endproperty
  a_rd_status: assert property (p_rd_status) else $error("status read wrong");
  property p_mask_wr;
    @(posedge clk) disable iff (sys_rst) wr_mask |=> mask == $past(req.wdata[3:0]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask write lost");
  property p_ctrl_wr;
    @(posedge clk) disable iff (sys_rst) wr_ctrl |=> wake_en == $past(req.wdata[cxwake_pkg::CTRL_WAKE_EN]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("wake enable write lost");
  property p_wake_off_reset;
    @(posedge clk) disable iff (sys_rst) !wake_active |=> pulse_cnt == 2'd0;
  endproperty
  a_wake_off_reset: assert property (p_wake_off_reset) else $error("counter kept while off");
endmodule // cxwake_top
`default_nettype wire
